// File: plt_pkg.sv
// constants, register map and state codes of the parts life and maintenance timer
package plt_pkg;
   localparam longint unsigned CLK_HZ       = 64'd50_000_000;
   localparam longint unsigned HOUR_S       = 64'd3600;
   localparam longint unsigned HOUR_CYC     = CLK_HZ * HOUR_S;
   localparam longint unsigned EXCITE_MS    = 64'd1000;
   localparam longint unsigned EXCITE_CYC   = CLK_HZ * EXCITE_MS / 64'd1000;
   localparam int unsigned     CTRL_HRS_PCT = 500;

   localparam logic [7:0] OFS_LIFE_STATUS = 8'h00;
   localparam logic [7:0] OFS_INRUSH_LIFE = 8'h04;
   localparam logic [7:0] OFS_CTRL_LIFE   = 8'h08;
   localparam logic [7:0] OFS_MAIN_LIFE   = 8'h0c;
   localparam logic [7:0] OFS_MEAS_CTRL   = 8'h10;
   localparam logic [7:0] OFS_MAINT_HOURS = 8'h14;
   localparam logic [7:0] OFS_MAINT_LIMIT = 8'h18;
   localparam logic [7:0] OFS_TERM_SEL_A  = 8'h1c;
   localparam logic [7:0] OFS_TERM_SEL_B  = 8'h20;

   localparam logic [6:0]  LIFE_FULL        = 7'h64;
   localparam logic [6:0]  INRUSH_ALARM_PCT = 7'h0a;
   localparam logic [6:0]  CTRL_ALARM_PCT   = 7'h0a;
   localparam logic [6:0]  MAIN_ALARM_PCT   = 7'h55;
   localparam logic [13:0] INRUSH_PER_PCT   = 14'h2710;
   localparam logic [6:0]  HOURS_PER_UNIT   = 7'h64;
   localparam logic [13:0] MAINT_MAX        = 14'h270e;
   localparam logic [13:0] MAINT_OFF        = 14'h270f;
   localparam logic [13:0] MAINT_LIMIT_RST  = 14'h270f;

   localparam logic [3:0] MC_IDLE   = 4'h0;
   localparam logic [3:0] MC_ARMED  = 4'h1;
   localparam logic [3:0] MC_RUN    = 4'h2;
   localparam logic [3:0] MC_DONE   = 4'h3;
   localparam logic [3:0] MC_FORCED = 4'h8;
   localparam logic [3:0] MC_ERROR  = 4'h9;

   localparam int ST_CTRL   = 0;
   localparam int ST_MAIN   = 1;
   localparam int ST_FAN    = 2;
   localparam int ST_INRUSH = 3;

   // selector codes 90, 190, 95, 195
   localparam logic [7:0] SEL_LIFE_POS  = 8'h5a;
   localparam logic [7:0] SEL_LIFE_NEG  = 8'hbe;
   localparam logic [7:0] SEL_MAINT_POS = 8'h5f;
   localparam logic [7:0] SEL_MAINT_NEG = 8'hc3;

   localparam int PIN_MAINS  = 0;
   localparam int PIN_INRUSH = 1;
   localparam int PIN_STOP   = 2;
   localparam int PIN_START  = 3;
   localparam int PIN_MOTOR  = 4;
   localparam int PIN_COAST  = 5;
   localparam int PIN_HOT    = 6;
   localparam int PIN_N      = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {MS_WAIT, MS_EXCITE} plt_meas_e;
endpackage

// File: plt_life_monitor.sv
// parts life monitor, capacitor measurement sequencer and maintenance timer
// How it works
// - every 10000 relay closings costs one percent
// - inrush life at 10 percent sets bit3
// - control capacitor life falls with hours, heat
// - control capacitor below 10 percent sets bit0
// - main capacitor life updated per completed measurement
// - main capacitor 85 percent or less sets bit1
// - measurement codes 0,1,2,3,8,9; reset idle
// - software writes only 0 or 1
// - armed plus mains loss starts DC measurement
// - DC excitation lasts one second
// - early power return may leave code 2
// - start, stop or bad motor aborts measurement
// - slow fan shows indication, sets bit2
// - any single worn fan raises fan condition
// - hourly save, 100 h units, clamp 9998
// - only whole powered hours are counted
// - writing zero clears the maintenance count
// - count reaching limit raises alarm; 9999 disables
// - maintenance indication follows the alarm
// - maintenance alarm on selector 95 or 195
// - life alarm on selector 90 or 190
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
module plt_life_monitor
   import plt_pkg::*;
#(
   parameter int              NFAN          = 2,
   parameter longint unsigned HOUR_CYCLES   = HOUR_CYC,
   parameter longint unsigned EXCITE_CYCLES = EXCITE_CYC,
   parameter int unsigned     CTRL_HOURS    = CTRL_HRS_PCT
) (
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic            mains_present,
   input  wire logic            inrush_closed,
   input  wire logic            output_stop_input,
   input  wire logic            start_cmd,
   input  wire logic            motor_present,
   input  wire logic            motor_coasting,
   input  wire logic            temp_high,
   input  wire logic [NFAN-1:0] fan_slow,
   input  wire logic [7:0]      cap_capacity_pct,
   output logic                 life_alarm_out,
   output logic                 maintenance_alarm_out,
   output logic                 term_a_out,
   output logic                 term_b_out,
   output logic                 fan_wear_indication,
   output logic                 maintenance_indication,
   output logic                 dc_excite,
   output logic                 nv_save
);
   localparam int HCW = $clog2(HOUR_CYCLES);
   localparam int ECW = $clog2(EXCITE_CYCLES);
   function automatic logic term_drive(input logic [7:0] sel, input logic life,
                                       input logic maint);
      case (sel)
         SEL_LIFE_POS:  term_drive = life;
         SEL_LIFE_NEG:  term_drive = ~life;
         SEL_MAINT_POS: term_drive = maint;
         SEL_MAINT_NEG: term_drive = ~maint;
         default:       term_drive = 1'b0;
      endcase
   endfunction
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction
   // pin synchronisers
   logic [PIN_N-1:0] pin_s1_r, pin_s2_r, pin_d_r;
   logic [NFAN-1:0]  fan_s1_r, fan_s2_r;
   logic [7:0]       cap_s1_r, cap_s2_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {pin_s1_r, pin_s2_r, pin_d_r, fan_s1_r, fan_s2_r, cap_s1_r, cap_s2_r} <= '0;
      end else begin
         pin_s1_r <= {temp_high, motor_coasting, motor_present, start_cmd,
                      output_stop_input, inrush_closed, mains_present};
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
         fan_s1_r <= fan_slow;
         fan_s2_r <= fan_s1_r;
         cap_s1_r <= cap_capacity_pct;
         cap_s2_r <= cap_s1_r;
      end
   end
   logic mains, mains_fall, mains_rise, close_pulse;
   assign mains       = pin_s2_r[PIN_MAINS];
   assign mains_fall  = pin_d_r[PIN_MAINS] & ~mains;
   assign mains_rise  = ~pin_d_r[PIN_MAINS] & mains;
   assign close_pulse = pin_s2_r[PIN_INRUSH] & ~pin_d_r[PIN_INRUSH];

   // axi4-lite slave
   logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic        wr_en;
   logic [31:0] wmask, rd_mux;
   logic        rd_hit, wr_hit;
   assign s_axi_awready = ~aw_got_r & ~bvalid_r;
   assign s_axi_wready  = ~w_got_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign wr_en = aw_got_r & w_got_r & ~bvalid_r;
   assign wmask = lane_mask(wstrb_r);
   assign wr_hit = (awaddr_r <= OFS_TERM_SEL_B) && (awaddr_r[1:0] == 2'h0);
   assign rd_hit = (s_axi_araddr <= OFS_TERM_SEL_B) && (s_axi_araddr[1:0] == 2'h0);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {aw_got_r, w_got_r, bvalid_r} <= '0;
         {awaddr_r, wdata_r, wstrb_r}  <= '0;
         bresp_r                       <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // life, measurement and timer state
   logic [3:0]  status_r;
   logic [6:0]  inrush_life_r, ctrl_life_r, main_life_r;
   logic [13:0] close_cnt_r;
   logic [15:0] ctrl_hr_acc_r;
   logic        main_measured_r;
   logic [3:0]  meas_code_r;
   plt_meas_e   meas_st_r;
   logic [ECW-1:0] exc_cnt_r;
   logic [HCW-1:0] hour_cyc_r;
   logic        hour_tick_r;
   logic [6:0]  sub_hours_r;
   logic [13:0] maint_hours_r, maint_limit_r;
   logic        maint_alarm_r;
   logic [7:0]  sel_a_r, sel_b_r;
   logic [NFAN-1:0] fan_worn_r;
   logic        life_alarm;
   logic [31:0] wd;
   logic        wr_meas, wr_hours, abort_stop, abort_motor, excite_end;
   assign wd          = wdata_r & wmask;
   assign wr_meas     = wr_en && awaddr_r == OFS_MEAS_CTRL;
   assign wr_hours    = wr_en && awaddr_r == OFS_MAINT_HOURS;
   assign abort_stop  = pin_s2_r[PIN_STOP] | pin_s2_r[PIN_START];
   assign abort_motor = ~pin_s2_r[PIN_MOTOR] | pin_s2_r[PIN_COAST];
   assign excite_end  = exc_cnt_r == ECW'(EXCITE_CYCLES - 64'd1);
   assign life_alarm  = |status_r;

   always_comb begin
      rd_mux = '0;
      case (s_axi_araddr)
         OFS_LIFE_STATUS: rd_mux[3:0]  = status_r;
         OFS_INRUSH_LIFE: rd_mux[6:0]  = inrush_life_r;
         OFS_CTRL_LIFE:   rd_mux[6:0]  = ctrl_life_r;
         OFS_MAIN_LIFE:   rd_mux[6:0]  = main_life_r;
         OFS_MEAS_CTRL:   rd_mux[3:0]  = meas_code_r;
         OFS_MAINT_HOURS: rd_mux[13:0] = maint_hours_r;
         OFS_MAINT_LIMIT: rd_mux[13:0] = maint_limit_r;
         OFS_TERM_SEL_A:  rd_mux[7:0]  = sel_a_r;
         OFS_TERM_SEL_B:  rd_mux[7:0]  = sel_b_r;
         default:         rd_mux = '0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {rvalid_r, rdata_r} <= '0;
         rresp_r             <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // inrush circuit wear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         close_cnt_r   <= '0;
         inrush_life_r <= LIFE_FULL;
      end else if (close_pulse) begin
         if (close_cnt_r == INRUSH_PER_PCT - 14'h1) begin
            close_cnt_r <= '0;
            if (inrush_life_r != '0)
               inrush_life_r <= inrush_life_r - 7'h1;
         end else begin
            close_cnt_r <= close_cnt_r + 14'h1;
         end
      end
   end
   // powered hour tick; a partial hour is dropped at power loss and restart
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {hour_cyc_r, hour_tick_r} <= '0;
      end else begin
         hour_tick_r <= 1'b0;
         if (!mains || mains_rise) begin
            hour_cyc_r <= '0;
         end else if (hour_cyc_r == HCW'(HOUR_CYCLES - 64'd1)) begin
            hour_cyc_r  <= '0;
            hour_tick_r <= 1'b1;
         end else begin
            hour_cyc_r <= hour_cyc_r + HCW'(1);
         end
      end
   end
   assign nv_save = hour_tick_r;

   // control capacitor ages faster when hot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_hr_acc_r <= '0;
         ctrl_life_r   <= LIFE_FULL;
      end else if (hour_tick_r) begin
         if (ctrl_hr_acc_r + 16'(pin_s2_r[PIN_HOT]) + 16'h1 >= 16'(CTRL_HOURS)) begin
            ctrl_hr_acc_r <= '0;
            if (ctrl_life_r != '0)
               ctrl_life_r <= ctrl_life_r - 7'h1;
         end else begin
            ctrl_hr_acc_r <= ctrl_hr_acc_r + 16'(pin_s2_r[PIN_HOT]) + 16'h1;
         end
      end
   end

   // main capacitor measurement sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meas_st_r       <= MS_WAIT;
         meas_code_r     <= MC_IDLE;
         exc_cnt_r       <= '0;
         main_life_r     <= LIFE_FULL;
         main_measured_r <= 1'b0;
      end else begin
         case (meas_st_r)
            MS_WAIT: begin
               if (meas_code_r == MC_ARMED && mains_fall) begin
                  meas_st_r   <= MS_EXCITE;
                  meas_code_r <= MC_RUN;
                  exc_cnt_r   <= '0;
               end else if (wr_meas && wd[31:4] == '0 && wd[3:1] == 3'h0) begin
                  meas_code_r <= wd[3:0];
               end
            end
            MS_EXCITE: begin
               if (abort_stop) begin
                  meas_st_r   <= MS_WAIT;
                  meas_code_r <= MC_FORCED;
               end else if (abort_motor) begin
                  meas_st_r   <= MS_WAIT;
                  meas_code_r <= MC_ERROR;
               end else if (mains) begin
                  meas_st_r <= MS_WAIT;
               end else if (excite_end) begin
                  meas_st_r       <= MS_WAIT;
                  meas_code_r     <= MC_DONE;
                  main_measured_r <= 1'b1;
                  main_life_r     <= (cap_s2_r > 8'(LIFE_FULL)) ? LIFE_FULL
                                                               : cap_s2_r[6:0];
               end else begin
                  exc_cnt_r <= exc_cnt_r + ECW'(1);
               end
            end
            default: meas_st_r <= MS_WAIT;
         endcase
      end
   end
   assign dc_excite = meas_st_r == MS_EXCITE;

   // per-fan wear flags
   genvar gi;
   generate
      for (gi = 0; gi < NFAN; gi++) begin : g_fan
         always_ff @(posedge aclk) begin
            if (!aresetn)
               fan_worn_r[gi] <= 1'b0;
            else if (fan_s2_r[gi])
               fan_worn_r[gi] <= 1'b1;
         end
      end
   endgenerate

   // life status word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
      end else begin
         status_r[ST_INRUSH] <= inrush_life_r <= INRUSH_ALARM_PCT;
         status_r[ST_CTRL]   <= ctrl_life_r < CTRL_ALARM_PCT;
         status_r[ST_MAIN]   <= main_measured_r && main_life_r <= MAIN_ALARM_PCT;
         status_r[ST_FAN]    <= |fan_worn_r;
      end
   end
   // maintenance timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {sub_hours_r, maint_hours_r} <= '0;
      end else if (wr_hours && wd[13:0] == 14'h0) begin
         {sub_hours_r, maint_hours_r} <= '0;
      end else if (hour_tick_r) begin
         if (sub_hours_r == HOURS_PER_UNIT - 7'h1) begin
            sub_hours_r <= '0;
            if (maint_hours_r < MAINT_MAX)
               maint_hours_r <= maint_hours_r + 14'h1;
         end else begin
            sub_hours_r <= sub_hours_r + 7'h1;
         end
      end
   end
   // software configuration and alarm outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         maint_limit_r      <= MAINT_LIMIT_RST;
         {sel_a_r, sel_b_r} <= '0;
      end else if (wr_en) begin
         if (awaddr_r == OFS_MAINT_LIMIT && wd[31:14] == '0 && wd[13:0] <= MAINT_OFF)
            maint_limit_r <= wd[13:0];
         if (awaddr_r == OFS_TERM_SEL_A)
            sel_a_r <= wd[7:0];
         if (awaddr_r == OFS_TERM_SEL_B)
            sel_b_r <= wd[7:0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {maint_alarm_r, term_a_out, term_b_out} <= '0;
      end else begin
         maint_alarm_r <= maint_limit_r != MAINT_OFF && maint_hours_r >= maint_limit_r;
         term_a_out    <= term_drive(sel_a_r, life_alarm, maint_alarm_r);
         term_b_out    <= term_drive(sel_b_r, life_alarm, maint_alarm_r);
      end
   end
   assign life_alarm_out         = life_alarm;
   assign maintenance_alarm_out  = maint_alarm_r;
   assign maintenance_indication = maint_alarm_r;
   assign fan_wear_indication    = status_r[ST_FAN];

   // checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_armed_loss;
      meas_st_r == MS_WAIT && meas_code_r == MC_ARMED && mains_fall;
   endsequence
   sequence s_clean_end;
      meas_st_r == MS_EXCITE && excite_end && !abort_stop && !abort_motor && !mains;
   endsequence

   a_inrush_alarm_bit: assert property (inrush_life_r <= INRUSH_ALARM_PCT |=> status_r[ST_INRUSH] && life_alarm_out) else $error("inrush alarm missing");
   a_ctrl_alarm_bit: assert property (ctrl_life_r < CTRL_ALARM_PCT |=> status_r[ST_CTRL]) else $error("control cap alarm missing");
   a_main_alarm_bit: assert property (s_clean_end ##0 cap_s2_r <= 8'(MAIN_ALARM_PCT) |=> ##1 status_r[ST_MAIN]) else $error("main cap alarm missing");
   a_meas_write_reject: assert property (meas_st_r == MS_WAIT && !mains_fall && wr_meas && wd[3:0] > MC_ARMED |=> $stable(meas_code_r)) else $error("illegal code accepted");
   a_meas_start_seq: assert property (s_armed_loss |=> meas_code_r == MC_RUN && dc_excite) else $error("measurement did not start");
   a_excite_done: assert property (s_clean_end |=> meas_code_r == MC_DONE && !dc_excite ##1 !dc_excite) else $error("excitation end wrong");
   a_stop_forced_end: assert property (dc_excite && abort_stop |=> meas_code_r == MC_FORCED && !dc_excite) else $error("forced end missing");
   a_fan_alarm_any: assert property (|fan_s2_r |=> ##1 status_r[ST_FAN] && fan_wear_indication) else $error("fan alarm missing");
   a_maint_hours_clamp: assert property (maint_hours_r <= MAINT_MAX) else $error("maintenance count above clamp");
   a_maint_clear_zero: assert property (wr_hours && wd[13:0] == 14'h0 |=> maint_hours_r == 14'h0) else $error("clear ignored");
   a_maint_alarm_set: assert property (maint_limit_r != MAINT_OFF && maint_hours_r >= maint_limit_r |=> maintenance_alarm_out && maintenance_indication) else $error("maintenance alarm missing");
   a_term_life_neg: assert property (sel_a_r == SEL_LIFE_NEG && $stable(sel_a_r) |-> term_a_out == !$past(life_alarm)) else $error("terminal a polarity wrong");
endmodule

// File: plt_plant_model.sv
// power stage, motor and fan model around the life timer
module plt_plant_model (
   input  wire logic       aclk,
   input  wire logic       power_req,
   input  wire logic       coast_req,
   input  wire logic [1:0] fan_req,
   input  wire logic [7:0] cap_req,
   input  wire logic       dc_excite,
   output logic            mains_present    = 1'h1,
   output logic            inrush_closed    = 1'h0,
   output logic            motor_present    = 1'h1,
   output logic            motor_coasting   = 1'h0,
   output logic [1:0]      fan_slow         = 2'h0,
   output logic [7:0]      cap_capacity_pct = 8'h64
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge aclk) begin
      if (!power_req)
         mains_present <= 1'h0;
      else if (!dc_excite)
         mains_present <= 1'h1; // power back only once the panel is dark
      inrush_closed <= mains_present;
      motor_present <= 1'h1; // motor stays wired and stopped
      motor_coasting <= coast_req;
      fan_slow <= fan_req;
      cap_capacity_pct <= cap_req;
   end
endmodule

// File: test_parts_life_and_maintenance_timer.sv
// testbench of the parts life and maintenance timer
module test_parts_life_and_maintenance_timer import plt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        start_cmd = 1'h0, output_stop_input = 1'h0, temp_high = 1'h0;
   logic        power_req = 1'h1, coast_req = 1'h0;
   logic [1:0]  fan_req = 2'h0, fan_slow;
   logic [7:0]  cap_req = 8'h64, cap_capacity_pct;
   logic        mains_present, inrush_closed, motor_present, motor_coasting;
   logic        life_alarm_out, maintenance_alarm_out, term_a_out, term_b_out;
   logic        fan_wear_indication, maintenance_indication, dc_excite, nv_save;
   logic [33:0] exp_q[$];
   logic [16:0] lfsr = 17'h14e1b;
   int          n_mismatch = 0, checks_done = 0, n;

   plt_life_monitor #(.NFAN(2), .HOUR_CYCLES(64'h14), .EXCITE_CYCLES(64'ha), .CTRL_HOURS(32'h2))
      i_plt_life_monitor (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mains_present, .inrush_closed,
      .output_stop_input, .start_cmd, .motor_present, .motor_coasting, .temp_high,
      .fan_slow, .cap_capacity_pct, .life_alarm_out, .maintenance_alarm_out, .term_a_out,
      .term_b_out, .fan_wear_indication, .maintenance_indication, .dc_excite, .nv_save);
   plt_plant_model i_plt_plant_model (.aclk, .power_req, .coast_req, .fan_req, .cap_req,
      .dc_excite, .mains_present, .inrush_closed, .motor_present, .motor_coasting,
      .fan_slow, .cap_capacity_pct);

   always #10 aclk = ~aclk;

   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction

   task automatic finish_test();
      if (n_mismatch == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      while (s_axi_bvalid !== 1'h1)
         @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      exp_q.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      while (s_axi_rvalid !== 1'h1)
         @(posedge aclk);
   endtask

   // arm, drop mains, optionally disturb the excitation, then read the code
   task automatic measure(input int flt, input logic [3:0] code);
      wr(OFS_MEAS_CTRL, 32'h1);
      power_req <= 1'h0;
      n = 0;
      while (dc_excite !== 1'h1)
         @(posedge aclk);
      start_cmd <= (flt == 1);
      output_stop_input <= (flt == 2);
      coast_req <= (flt == 3);
      while (dc_excite === 1'h1) begin
         @(posedge aclk);
         n++;
      end
      if (flt == 0)
         chk("excite cycles", 34'ha, 34'(n));
      start_cmd <= 1'h0;
      output_stop_input <= 1'h0;
      coast_req <= 1'h0;
      power_req <= 1'h1;
      repeat (8) @(posedge aclk);
      rd(OFS_MEAS_CTRL, {28'h0, code});
   endtask

   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready)
         chk("write response", exp_q.pop_front(), {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready)
         chk("read data", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
   end

   initial begin
      #400000;
      n_mismatch++;
      finish_test();
   end

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(OFS_LIFE_STATUS, 32'h0);
      rd(OFS_INRUSH_LIFE, 32'h64);
      rd(OFS_CTRL_LIFE, 32'h64);
      rd(OFS_MAIN_LIFE, 32'h64);
      rd(OFS_MAINT_HOURS, 32'h0);
      rd(OFS_MAINT_LIMIT, 32'h270f);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(8'h40, 32'h1, RESP_SLVERR);
      for (int c = 2; c < 10; c++) begin
         wr(OFS_MEAS_CTRL, 32'(c));
         rd(OFS_MEAS_CTRL, 32'h0);
      end
      lfsr = lfsr_next(lfsr);
      cap_req <= 8'(lfsr % 17'h56);
      measure(0, MC_DONE);
      rd(OFS_MAIN_LIFE, {24'h0, cap_req});
      rd(OFS_LIFE_STATUS, 32'h2);
      chk("life alarm", 34'h1, 34'(life_alarm_out));
      for (int f = 1; f < 4; f++)
         measure(f, (f == 3) ? MC_ERROR : MC_FORCED);
      fan_req <= 2'h2;
      repeat (6) @(posedge aclk);
      chk("fan indication", 34'h1, 34'(fan_wear_indication));
      rd(OFS_LIFE_STATUS, 32'h6);
      wr(OFS_TERM_SEL_A, 32'h5f);
      wr(OFS_TERM_SEL_B, 32'hc3);
      wr(OFS_MAINT_LIMIT, 32'h1);
      temp_high <= 1'h1;
      chk("maint alarm early", 34'h0, 34'(maintenance_alarm_out));
      n = 0;
      while (maintenance_alarm_out !== 1'h1 && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      chk("whole hours only", 34'h1, 34'(n > 1800));
      rd(OFS_MAINT_HOURS, 32'h1);
      while (nv_save !== 1'h1)
         @(posedge aclk);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (nv_save !== 1'h1);
      chk("save period", 34'h14, 34'(n));
      chk("maint panel", 34'h1, 34'(maintenance_indication));
      chk("term a maint", 34'h1, 34'(term_a_out));
      chk("term b maint", 34'h0, 34'(term_b_out));
      rd(OFS_LIFE_STATUS, 32'h7);
      wr(OFS_MAINT_HOURS, 32'h5);
      rd(OFS_MAINT_HOURS, 32'h1);
      wr(OFS_MAINT_HOURS, 32'h0);
      rd(OFS_MAINT_HOURS, 32'h0);
      wr(OFS_TERM_SEL_A, 32'hbe);
      wr(OFS_TERM_SEL_B, 32'h5a);
      repeat (3) @(posedge aclk);
      chk("maint alarm clear", 34'h0, 34'(maintenance_alarm_out));
      chk("term a life", 34'h0, 34'(term_a_out));
      chk("term b life", 34'h1, 34'(term_b_out));
      finish_test();
   end
endmodule
